// ==== verilog/sio_pkg.sv ====
package sio_pkg;

    // data widths
    localparam int SPD_W  = 16;
    localparam int TRQ_W  = 16;
    localparam int POS_W  = 24;
    localparam int ALM_W  = 3;

    // terminal polarity settings for an input function
    localparam logic [2:0] POL_LOW     = 3'h0;
    localparam logic [2:0] POL_HIGH    = 3'h1;
    localparam logic [2:0] POL_RISE    = 3'h2;
    localparam logic [2:0] POL_FALL    = 3'h3;
    localparam logic [2:0] POL_BOTH    = 3'h4;

    // speed limit source setting that enables the input-selected limit
    localparam logic [1:0] SPD_LIM_SRC_INPUT = 2'h2;
    // position command source setting for pulse commands
    localparam logic [1:0] POS_SRC_PULSE     = 2'h0;

    // reset values
    localparam logic [POS_W-1:0] POS_ERR_RST = 24'h00_0000;
    localparam logic [SPD_W-1:0] SPD_LIM_RST = 16'h0000;

    // number of assignable input functions
    localparam int NUM_IN = 5;
    localparam int IN_INHIBIT = 0;
    localparam int IN_ESTOP   = 1;
    localparam int IN_CLR_ERR = 2;
    localparam int IN_LIM_SEL = 3;
    localparam int IN_PULSE_INH = 4;

    // control modes
    typedef enum logic [1:0] {
        SIO_MODE_POS,
        SIO_MODE_SPD,
        SIO_MODE_TRQ
    } sio_mode_type;

    // drive state handed to the block
    typedef struct packed {
        logic                     enable_ok;
        logic                     fault;
        logic [ALM_W-1:0]         alarm_code;
        logic                     brake_release;
        logic                     torque_clamped;
        logic                     fixed_len_done;
        logic                     mech_home_done;
        logic                     elec_home_done;
    } sio_state_type;

    // thresholds and settings
    typedef struct packed {
        logic [SPD_W-1:0]         rotate_threshold;
        logic [SPD_W-1:0]         speed_deviation_window;
        logic [POS_W-1:0]         positioning_complete_range;
        logic [POS_W-1:0]         positioning_positioning_out_a_range;
        logic [TRQ_W-1:0]         torque_set;
        logic [SPD_W-1:0]         speed_set;
        logic [SPD_W-1:0]         speed_limit_value_a;
        logic [SPD_W-1:0]         speed_limit_value_b;
        logic [1:0]               speed_limit_source_param;
        logic [1:0]               position_command_source_param;
    } sio_cfg_type;

    // status outputs
    typedef struct packed {
        logic servo_ready;
        logic motor_rotating_out;
        logic zero_speed;
        logic speed_match_out;
        logic positioning_complete_out;
        logic positioning_out_a;
        logic torque_limiting_out;
        logic speed_limiting_out;
        logic holding_brake_out;
        logic fault_out;
        logic alarm_code_bit0;
        logic alarm_code_bit1;
        logic alarm_code_bit2;
        logic fixed_len_done_out;
        logic homing_done_out;
        logic electrical_home_done_out;
        logic torque_reached_out;
        logic speed_reached_out;
    } sio_out_type;

endpackage

// ==== verilog/sio_logic.sv ====
`timescale 1ns/10ps

// Functional notes
// - inhibit input set to rising edge is treated as high-level active
// - inhibit input set to falling or both edges is treated as low-level active
// - active inhibit blocks the interrupt fixed-length move, inactive allows it
// - emergency stop brings speed to zero then locks position
// - clear-error input zeroes accumulated position deviation, else it accumulates taken pulses minus feedback
// - limit source 2: select input picks limit a, else limit b, both directions
// - pulse source in position mode: pulse-inhibit input drops command pulses
// - ready output high when an enable request can be accepted
// - rotating output high while speed exceeds threshold
// - zero-speed output high only when speed is zero
// - speed mode: match when speed error below deviation window
// - position mode: complete when deviation within completion range
// - position mode: positioning_out_a when deviation within positioning_out_a range
// - torque-limiting output follows torque clamp state
// - torque mode: speed-limiting output follows speed clamp state
// - brake output high releases brake, low engages it
// - fault output high while a fault is detected
// - alarm code presented as three separate bit outputs
// - done output high once fixed-length move finished
// - separate mechanical and electrical homing done outputs
// - torque reached when absolute torque at or above set value
// - speed reached when absolute speed feedback at or above set value
module sio_logic (
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rstn,
    // input terminals and their polarity settings
    input  wire logic [sio_pkg::NUM_IN-1:0]  terminal_in,
    input  wire logic [sio_pkg::NUM_IN*3-1:0] terminal_pol,
    // drive quantities
    input  wire sio_pkg::sio_mode_type       mode,
    input  wire logic signed [15:0]          speed_fb,
    input  wire logic signed [15:0]          speed_cmd,
    input  wire logic signed [15:0]          torque_fb,
    input  wire logic                        cmd_pulse,
    input  wire logic signed [23:0]          pulse_delta,
    input  wire logic signed [23:0]          fb_delta,
    input  wire sio_pkg::sio_state_type      drive_state,
    input  wire sio_pkg::sio_cfg_type        cfg,
    // control actions
    output logic                             fixed_length_irq_inhibit,
    output logic                             estop_active,
    output logic                             clear_position_error_in,
    output logic                             speed_limit_source_select,
    output logic [15:0]                      speed_limit_q,
    output logic                             position_lock_q,
    output logic signed [23:0]               pos_err_q,
    // status outputs
    output sio_pkg::sio_out_type             status_q
);

    logic [sio_pkg::NUM_IN-1:0] sync1_q;
    logic [sio_pkg::NUM_IN-1:0] sync2_q;
    logic [sio_pkg::NUM_IN-1:0] prev_q;
    logic [sio_pkg::NUM_IN-1:0] func_q;
    logic [sio_pkg::NUM_IN-1:0] func_d;
    logic [15:0]                spd_abs;
    logic [15:0]                trq_abs;
    logic [16:0]                spd_diff;
    logic [16:0]                spd_diff_abs;
    logic [23:0]                err_abs;
    logic                       spd_clamped;
    logic                       pulse_taken;

    // two-stage synchroniser on every terminal
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= terminal_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // per-input polarity and edge decode
    genvar gi;
    generate
        for (gi = 0; gi < sio_pkg::NUM_IN; gi = gi + 1) begin : g_in
            logic [2:0] pol;
            always_comb begin
                pol = terminal_pol[gi*3 +: 3];
                if (gi == sio_pkg::IN_INHIBIT) begin
                    // inhibit must be level sensitive: edges are forced to levels
                    if (pol == sio_pkg::POL_RISE) begin
                        pol = sio_pkg::POL_HIGH;
                    end else if (pol == sio_pkg::POL_FALL || pol == sio_pkg::POL_BOTH) begin
                        pol = sio_pkg::POL_LOW;
                    end
                end
                unique case (pol)
                    sio_pkg::POL_LOW:  func_d[gi] = ~sync2_q[gi];
                    sio_pkg::POL_HIGH: func_d[gi] = sync2_q[gi];
                    sio_pkg::POL_RISE: func_d[gi] = sync2_q[gi] & ~prev_q[gi];
                    sio_pkg::POL_FALL: func_d[gi] = ~sync2_q[gi] & prev_q[gi];
                    sio_pkg::POL_BOTH: func_d[gi] = sync2_q[gi] ^ prev_q[gi];
                    default:           func_d[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    // registered function states
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            func_q <= '0;
        end else begin
            func_q <= func_d;
        end
    end

    // control actions out of the decoded functions
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fixed_length_irq_inhibit  <= 1'b0;
            estop_active              <= 1'b0;
            clear_position_error_in   <= 1'b0;
            speed_limit_source_select <= 1'b0;
        end else begin
            fixed_length_irq_inhibit  <= func_d[sio_pkg::IN_INHIBIT];
            estop_active              <= func_d[sio_pkg::IN_ESTOP];
            clear_position_error_in   <= func_d[sio_pkg::IN_CLR_ERR];
            speed_limit_source_select <= func_d[sio_pkg::IN_LIM_SEL];
        end
    end

    // speed limit selection for torque mode
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            speed_limit_q <= sio_pkg::SPD_LIM_RST;
        end else if (cfg.speed_limit_source_param == sio_pkg::SPD_LIM_SRC_INPUT) begin
            speed_limit_q <= func_q[sio_pkg::IN_LIM_SEL] ? cfg.speed_limit_value_a
                                                          : cfg.speed_limit_value_b;
        end else begin
            speed_limit_q <= cfg.speed_limit_value_b;
        end
    end

    // emergency stop: lock position once speed has reached zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            position_lock_q <= 1'b0;
        end else if (!func_q[sio_pkg::IN_ESTOP]) begin
            position_lock_q <= 1'b0;
        end else if (speed_fb == 16'sh0000) begin
            position_lock_q <= 1'b1;
        end
    end

    // command pulses dropped while inhibited in pulse-source position mode
    assign pulse_taken = cmd_pulse &&
        !(mode == sio_pkg::SIO_MODE_POS &&
          cfg.position_command_source_param == sio_pkg::POS_SRC_PULSE &&
          func_q[sio_pkg::IN_PULSE_INH]);

    // position deviation accumulator
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pos_err_q <= sio_pkg::POS_ERR_RST;
        end else if (func_q[sio_pkg::IN_CLR_ERR]) begin
            pos_err_q <= sio_pkg::POS_ERR_RST;
        end else begin
            pos_err_q <= pos_err_q + (pulse_taken ? pulse_delta : 24'sh00_0000) - fb_delta;
        end
    end

    // magnitudes for the comparisons
    always_comb begin
        spd_abs      = speed_fb[15] ? 16'(-speed_fb) : 16'(speed_fb);
        trq_abs      = torque_fb[15] ? 16'(-torque_fb) : 16'(torque_fb);
        spd_diff     = 17'({speed_fb[15], speed_fb} - {speed_cmd[15], speed_cmd});
        spd_diff_abs = spd_diff[16] ? 17'(-spd_diff) : spd_diff;
        err_abs      = pos_err_q[23] ? 24'(-pos_err_q) : 24'(pos_err_q);
        spd_clamped  = mode == sio_pkg::SIO_MODE_TRQ && spd_abs >= speed_limit_q;
    end

    // status outputs, all registered
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            status_q <= '0;
        end else begin
            status_q.servo_ready              <= drive_state.enable_ok && !drive_state.fault;
            status_q.motor_rotating_out       <= spd_abs > cfg.rotate_threshold;
            status_q.zero_speed               <= spd_abs == 16'h0000;
            status_q.speed_match_out          <= mode == sio_pkg::SIO_MODE_SPD &&
                                                 spd_diff_abs < {1'b0, cfg.speed_deviation_window};
            status_q.positioning_complete_out <= mode == sio_pkg::SIO_MODE_POS &&
                                                 err_abs <= cfg.positioning_complete_range;
            status_q.positioning_out_a        <= mode == sio_pkg::SIO_MODE_POS &&
                                                 err_abs <= cfg.positioning_positioning_out_a_range;
            status_q.torque_limiting_out      <= drive_state.torque_clamped;
            status_q.speed_limiting_out       <= spd_clamped;
            status_q.holding_brake_out        <= drive_state.brake_release;
            status_q.fault_out                <= drive_state.fault;
            status_q.alarm_code_bit0          <= drive_state.alarm_code[0];
            status_q.alarm_code_bit1          <= drive_state.alarm_code[1];
            status_q.alarm_code_bit2          <= drive_state.alarm_code[2];
            status_q.fixed_len_done_out       <= drive_state.fixed_len_done;
            status_q.homing_done_out          <= drive_state.mech_home_done;
            status_q.electrical_home_done_out <= drive_state.elec_home_done;
            status_q.torque_reached_out       <= trq_abs >= cfg.torque_set;
            status_q.speed_reached_out        <= spd_abs >= cfg.speed_set;
        end
    end

endmodule

// ==== tb/sio_sva.sv ====
`timescale 1ns/10ps
module sio_sva (
    // clock and reset
    input wire logic                   clk_sys,
    input wire logic                   rstn,
    // watched inputs
    input wire logic [4:0]             terminal_in,
    input wire logic [14:0]            terminal_pol,
    input wire sio_pkg::sio_mode_type  mode,
    input wire logic signed [15:0]     speed_fb,
    input wire sio_pkg::sio_state_type drive_state,
    input wire sio_pkg::sio_cfg_type   cfg,
    // watched outputs
    input wire logic                   fixed_length_irq_inhibit,
    input wire logic                   estop_active,
    input wire logic                   position_lock_q,
    input wire logic signed [23:0]     pos_err_q,
    input wire sio_pkg::sio_out_type   status_q
);
    logic [1:0]  up_q;
    logic        live;
    logic [23:0] err_mag;
    logic        in_range;
    // count edges since reset so outputs have left their reset value
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    // deviation magnitude against the completion range
    assign live     = up_q == 2'h3;
    assign err_mag  = pos_err_q[23] ? 24'(-pos_err_q) : 24'(pos_err_q);
    assign in_range = err_mag <= cfg.positioning_complete_range;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_ready_follow: assert property (live |-> status_q.servo_ready ==
        ($past(drive_state.enable_ok) && !$past(drive_state.fault))) else $error("ready wrong");
    a_fault_follow: assert property (live |-> status_q.fault_out == $past(drive_state.fault))
        else $error("fault wrong");
    a_alarm_bits: assert property (live |-> {status_q.alarm_code_bit2, status_q.alarm_code_bit1,
        status_q.alarm_code_bit0} == $past(drive_state.alarm_code)) else $error("alarm code wrong");
    a_brake_follow: assert property (live |-> status_q.holding_brake_out == $past(drive_state.brake_release))
        else $error("brake wrong");
    a_zero_speed: assert property (live |-> status_q.zero_speed == ($past(speed_fb) == 16'h0000))
        else $error("zero speed wrong");
    a_clamp_flag: assert property (live |-> status_q.torque_limiting_out == $past(drive_state.torque_clamped))
        else $error("torque limiting wrong");
    a_inh_rise: assert property ((live && terminal_pol[2:0] == sio_pkg::POL_RISE && $stable(terminal_in[0]))[*4]
        |-> fixed_length_irq_inhibit == terminal_in[0]) else $error("rise setting not high level");
    a_inh_fall: assert property ((live && terminal_pol[2:0] >= sio_pkg::POL_FALL
        && terminal_pol[2:0] <= sio_pkg::POL_BOTH && $stable(terminal_in[0]))[*4]
        |-> fixed_length_irq_inhibit == !terminal_in[0]) else $error("edge setting not low level");
    a_estop_lock: assert property (live && estop_active && speed_fb == 16'h0000 |-> ##[1:2] position_lock_q)
        else $error("no lock at zero speed");
    a_done_range: assert property (live && mode == sio_pkg::SIO_MODE_POS
        |=> status_q.positioning_complete_out == $past(in_range)) else $error("complete wrong");
    c_estop: cover property (estop_active && position_lock_q);
    c_inhibit: cover property (fixed_length_irq_inhibit);
    c_complete: cover property (status_q.positioning_complete_out);
endmodule
bind sio_logic sio_sva u_sva (.clk_sys, .rstn, .terminal_in, .terminal_pol, .mode, .speed_fb, .drive_state, .cfg,
    .fixed_length_irq_inhibit, .estop_active, .position_lock_q, .pos_err_q, .status_q);

// ==== tb/sio_host.sv ====
`timescale 1ns/10ps
module sio_host (
    // clock
    input  wire logic       clk_sys,
    // requested levels
    input  wire logic [4:0] want,
    // terminals toward the drive
    output logic [4:0]      terminal_in
);
    // levels change once per edge and stand at least one full period
    initial terminal_in = 5'h00;
    always @(posedge clk_sys) begin
        terminal_in <= want;
    end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
    logic                   clk_sys, rstn, cmd_pulse;
    logic [4:0]             want, terminal_in;
    logic [14:0]            terminal_pol;
    sio_pkg::sio_mode_type  mode;
    logic signed [15:0]     speed_fb, speed_cmd, torque_fb, lim;
    logic signed [23:0]     pulse_delta, fb_delta, err, base;
    sio_pkg::sio_state_type st;
    sio_pkg::sio_cfg_type   cfg;
    sio_pkg::sio_out_type   stat;
    logic                   inhibit, estop, clr, lsel, lock;
    int                     error_cnt, checks_done, seed, ex, k;
    sio_host u_host (.clk_sys(clk_sys), .want(want), .terminal_in(terminal_in));
    sio_logic u_dut (.clk_sys(clk_sys), .rstn(rstn), .terminal_in(terminal_in), .terminal_pol(terminal_pol),
        .mode(mode), .speed_fb(speed_fb), .speed_cmd(speed_cmd), .torque_fb(torque_fb), .cmd_pulse(cmd_pulse),
        .pulse_delta(pulse_delta), .fb_delta(fb_delta), .drive_state(st), .cfg(cfg),
        .fixed_length_irq_inhibit(inhibit), .estop_active(estop), .clear_position_error_in(clr),
        .speed_limit_source_select(lsel), .speed_limit_q(lim), .position_lock_q(lock), .pos_err_q(err),
        .status_q(stat));
    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_stat(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t status got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // random drive state against the integer model, one status per edge
    task automatic run_random;
        sio_pkg::sio_out_type e;
        int s, c, t;
        mode = sio_pkg::SIO_MODE_SPD;
        for (k = 0; k < 300; k++) begin
            st = 10'($random(seed));
            cfg.rotate_threshold = 16'($random(seed) & 15);
            cfg.speed_deviation_window = 16'($random(seed) & 15);
            cfg.speed_set = 16'($random(seed) & 31);
            cfg.torque_set = 16'($random(seed) & 31);
            s = $random(seed) & 31;
            c = $random(seed) & 31;
            t = $random(seed) % 40;
            speed_fb = 16'(s);
            speed_cmd = 16'(c);
            torque_fb = 16'(t);
            e = '0;
            e.servo_ready = st.enable_ok && !st.fault;
            e.motor_rotating_out = s > int'(cfg.rotate_threshold);
            e.zero_speed = s == 0;
            e.speed_match_out = (s > c ? s - c : c - s) < int'(cfg.speed_deviation_window);
            e.torque_limiting_out = st.torque_clamped;
            e.holding_brake_out = st.brake_release;
            e.fault_out = st.fault;
            {e.alarm_code_bit2, e.alarm_code_bit1, e.alarm_code_bit0} = st.alarm_code;
            e.fixed_len_done_out = st.fixed_len_done;
            e.homing_done_out = st.mech_home_done;
            e.electrical_home_done_out = st.elec_home_done;
            e.torque_reached_out = (t < 0 ? -t : t) >= int'(cfg.torque_set);
            e.speed_reached_out = s >= int'(cfg.speed_set);
            step(1);
            chk_stat(stat & 18'h3_cfff, e);
        end
    endtask
    // watchdog against a hang
    initial begin
        #200000;
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish();
    end
    // main sequence
    initial begin
        seed = 94551;
        error_cnt = 0;
        checks_done = 0;
        {rstn, cmd_pulse, want, speed_fb, speed_cmd, torque_fb, pulse_delta, fb_delta, st, cfg} = '0;
        terminal_pol = 15'h1249;
        mode = sio_pkg::SIO_MODE_POS;
        cfg.positioning_complete_range = 24'h00_0032;
        cfg.positioning_positioning_out_a_range = 24'h00_001e;
        cfg.speed_limit_value_a = 16'h0123;
        cfg.speed_limit_value_b = 16'h0456;
        repeat (5) @(posedge clk_sys);
        #1 rstn = 1'b1;
        for (k = 0; k < 10; k++) begin
            terminal_pol[2:0] = 3'(k / 2);
            want[0] = k[0];
            step(6);
            ex = (k / 2 == 1 || k / 2 == 2) ? k % 2 : 1 - k % 2;
            chk_val(inhibit, ex, "inhibit");
        end
        terminal_pol[2:0] = 3'h1;
        want[0] = 1'b0;
        $display("inhibit polarity test done");
        for (k = 0; k < 4; k++) begin
            cfg.speed_limit_source_param = k[1] ? 2'h0 : 2'h2;
            want[3] = k[0];
            step(6);
            chk_val(lim, (k == 1) ? 16'h0123 : 16'h0456, "limit");
            chk_val(lsel, k[0], "select");
        end
        $display("speed limit test done");
        pulse_delta = 24'sh00_0005;
        for (k = 0; k < 2; k++) begin
            want[4] = !k[0];
            step(6);
            base = err;
            cmd_pulse = 1'b1;
            step(8);
            cmd_pulse = 1'b0;
            step(3);
            chk_val(err, base + (k == 1 ? 40 : 0), "deviation");
        end
        chk_val(stat.positioning_complete_out, 1, "complete");
        chk_val(stat.positioning_out_a, 0, "positioning_out_a");
        want[2] = 1'b1;
        step(6);
        chk_val(clr, 1, "clear level");
        chk_val(err, 0, "cleared");
        want[2] = 1'b0;
        $display("pulse and clear test done");
        speed_fb = 16'sh0064;
        want[1] = 1'b1;
        step(6);
        chk_val({estop, lock}, 2'h2, "stop moving");
        speed_fb = 16'sh0000;
        step(2);
        chk_val(lock, 1, "locked");
        want[1] = 1'b0;
        step(6);
        // rising-edge setting on the stop input gives a one-cycle pulse
        terminal_pol[5:3] = sio_pkg::POL_RISE;
        want[1] = 1'b1;
        step(4);
        chk_val(estop, 1, "stop edge");
        step(1);
        chk_val(estop, 0, "stop edge end");
        want[1] = 1'b0;
        step(6);
        terminal_pol[5:3] = sio_pkg::POL_HIGH;
        $display("emergency stop test done");
        run_random();
        $display("random status test done");
        // torque mode: speed at or above the selected limit is flagged
        mode = sio_pkg::SIO_MODE_TRQ;
        speed_fb = 16'sh0500;
        step(2);
        chk_val(stat.speed_limiting_out, 1, "speed limited");
        speed_fb = 16'sh0100;
        step(2);
        chk_val(stat.speed_limiting_out, 0, "speed free");
        $display("speed limiting test done");
        tally_and_finish();
    end
endmodule
